// file: src/alu_pkg.sv
// Purpose: Shared constants and types for the shift/ALU datapath
// Assumes: APB register map, 32-bit data, byte addresses
// Notes:   Field positions refer to the control word
package alu_pkg;
   // ********************
   // Register map
   // ********************
   localparam logic [7:0] OFF_OPA    = 8'h00;
   localparam logic [7:0] OFF_OPB    = 8'h04;
   localparam logic [7:0] OFF_AMT    = 8'h08;
   localparam logic [7:0] OFF_CTRL   = 8'h0C;
   localparam logic [7:0] OFF_RESULT = 8'h10;
   localparam logic [7:0] OFF_STATUS = 8'h14;
   localparam logic [7:0] OFF_INFO   = 8'h18;

   // ********************
   // Control word fields
   // ********************
   localparam int unsigned OP_LSB   = 0;
   localparam int unsigned OP_W     = 4;
   localparam int unsigned ST_LSB   = 4;
   localparam int unsigned ST_W     = 2;
   localparam int unsigned FORM_LSB = 6;
   localparam int unsigned FORM_W   = 2;
   localparam int unsigned CAMT_LSB = 8;
   localparam int unsigned CAMT_W   = 5;
   localparam int unsigned IMM_LSB  = 13;
   localparam int unsigned IMM_W    = 8;
   localparam int unsigned ROT_LSB  = 21;
   localparam int unsigned ROT_W    = 4;
   localparam int unsigned FW_BIT   = 25;
   localparam int unsigned IDX_BIT  = 26;

   // ********************
   // Status and info bits
   // ********************
   localparam int unsigned ST_N = 3;
   localparam int unsigned ST_Z = 2;
   localparam int unsigned ST_C = 1;
   localparam int unsigned ST_V = 0;
   localparam logic [3:0]  STATUS_RST = 4'h0;
   localparam int unsigned INFO_DEST  = 0;
   localparam int unsigned INFO_REJ   = 1;
   localparam int unsigned INFO_FLAGS = 2;
   localparam logic [2:0]  INFO_RST   = 3'h0;
   localparam logic [31:0] WORD_RST   = 32'h0000_0000;
   localparam logic [7:0]  FULL_SHIFT = 8'h20;

   // Left shift alias shares the left logical code
   typedef enum logic [1:0] {
      shift_left_logical, shift_right_logical, shift_right_signed, rotate_right_op
   } shift_e;
   typedef enum logic [1:0] {form_plain, form_const, form_reg, form_imm} form_e;
   typedef enum logic [3:0] {
      add_op, add_carry_op, and_op, mask_clear_op, compare_negated_op, compare_op,
      xor_op, copy_op, copy_inverted_op, disj_op, reverse_difference_op,
      reverse_difference_borrow_op, difference_borrow_op, difference_op,
      equivalence_test_op, mask_test_op
   } op_e;
endpackage : alu_pkg

// file: src/barrel_shifter.sv
// Purpose: 32-bit barrel shifter with carry-out
// Assumes: Amount already reduced to the byte used as count
// Notes:   Zero amount passes value and carry through unless rotate_through_carry is set
`timescale 1ns/10ps
`default_nettype none
module barrel_shifter (
   input  wire logic [31:0]          value,
   input  wire logic [7:0]           amount,
   input  wire alu_pkg::shift_e      kind,
   input  wire logic                 rotate_through_carry,
   input  wire logic                 carry_in,
   output logic      [31:0]          result,
   output logic                      carry_out
);
   logic [63:0] wide;
   logic [5:0]  n6;
   logic        big;

   // Counts above 32 saturate except on rotates, which use amount[4:0]; the flags below pick the fill
   assign big = amount > alu_pkg::FULL_SHIFT;
   assign n6  = big ? alu_pkg::FULL_SHIFT[5:0] : amount[5:0];

   always_comb begin
      result    = value;
      carry_out = carry_in;
      wide      = {32'h0000_0000, value};
      if (rotate_through_carry) begin
         result    = {carry_in, value[31:1]};
         carry_out = value[0];
      end else if (amount != 8'h00) begin
         unique case (kind)
            alu_pkg::shift_left_logical: begin
               wide      = {32'h0000_0000, value} << n6;
               result    = big ? 32'h0000_0000 : wide[31:0];
               carry_out = big ? 1'b0 : wide[32];
            end
            alu_pkg::shift_right_logical: begin
               wide      = {value, 32'h0000_0000} >> n6;
               result    = big ? 32'h0000_0000 : wide[63:32];
               carry_out = big ? 1'b0 : wide[31];
            end
            alu_pkg::shift_right_signed: begin
               wide      = 64'($signed({value, 32'h0000_0000}) >>> n6);
               result    = wide[63:32];
               carry_out = big ? value[31] : wide[31];
            end
            alu_pkg::rotate_right_op: begin
               wide      = {value, value} >> amount[4:0];
               result    = wide[31:0];
               carry_out = wide[31];
            end
         endcase
      end
   end
endmodule : barrel_shifter
`default_nettype wire

// file: src/alu_datapath.sv
// Purpose: Shifter plus sixteen-operation ALU behind an APB slave
// Assumes: Single clock, APB master holds requests until pready
// Notes:   Writing the control word executes one operation
//
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module alu_datapath (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr
);
   // ********************
   // Storage
   // ********************
   logic [31:0] opa_q;
   logic [31:0] opb_q;
   logic [31:0] amt_q;
   logic [31:0] ctrl_q;
   logic [31:0] result_q;
   logic [3:0]  status_q;
   logic [2:0]  info_q;
   logic [31:0] prdata_q;
   logic        pready_q;
   logic        pslverr_q;

   function automatic logic is_mapped(input logic [7:0] a);
      return a == alu_pkg::OFF_OPA || a == alu_pkg::OFF_OPB ||
             a == alu_pkg::OFF_AMT || a == alu_pkg::OFF_CTRL ||
             a == alu_pkg::OFF_RESULT || a == alu_pkg::OFF_STATUS ||
             a == alu_pkg::OFF_INFO;
   endfunction : is_mapped

   // ********************
   // Bus decode
   // ********************
   wire setup  = psel & ~penable;
   wire done   = psel & penable & pready_q;
   wire wr     = done & pwrite;
   wire wr_opa = wr & (paddr == alu_pkg::OFF_OPA);
   wire wr_opb = wr & (paddr == alu_pkg::OFF_OPB);
   wire wr_amt = wr & (paddr == alu_pkg::OFF_AMT);
   wire wr_st  = wr & (paddr == alu_pkg::OFF_STATUS);
   wire exec   = wr & (paddr == alu_pkg::OFF_CTRL);

   // Control fields are taken from the write data so a read that follows
   // at once already sees the result
   alu_pkg::op_e    op_w;
   alu_pkg::shift_e kind_w;
   alu_pkg::form_e  form_w;
   wire [4:0] camt_w = pwdata[alu_pkg::CAMT_LSB +: alu_pkg::CAMT_W];
   wire [7:0] imm_w  = pwdata[alu_pkg::IMM_LSB +: alu_pkg::IMM_W];
   wire [3:0] rot_w  = pwdata[alu_pkg::ROT_LSB +: alu_pkg::ROT_W];
   wire       fw_w   = pwdata[alu_pkg::FW_BIT];
   wire       idx_w  = pwdata[alu_pkg::IDX_BIT];
   assign op_w   = alu_pkg::op_e'(pwdata[alu_pkg::OP_LSB +: alu_pkg::OP_W]);
   assign kind_w = alu_pkg::shift_e'(pwdata[alu_pkg::ST_LSB +: alu_pkg::ST_W]);
   assign form_w = alu_pkg::form_e'(pwdata[alu_pkg::FORM_LSB +: alu_pkg::FORM_W]);

   // ********************
   // Shifter operand
   // ********************
   wire form_imm   = form_w == alu_pkg::form_imm;
   wire form_const = form_w == alu_pkg::form_const;
   wire form_reg   = form_w == alu_pkg::form_reg;
   wire right_kind = kind_w == alu_pkg::shift_right_logical ||
                     kind_w == alu_pkg::shift_right_signed;
   // Constant zero on the rotate selects the extended rotate
   wire rrx_w      = form_const && kind_w == alu_pkg::rotate_right_op &&
                     camt_w == 5'h00;
   // Constant zero on right shifts encodes a full 32 place shift
   wire [7:0] camt8 = (camt_w == 5'h00 && right_kind) ?
                      alu_pkg::FULL_SHIFT : {3'h0, camt_w};
   wire [7:0] sh_amt = form_imm   ? {3'h0, rot_w, 1'b0} :
                       form_reg   ? amt_q[7:0] :
                       form_const ? camt8 : 8'h00;
   wire [31:0] sh_in = form_imm ? {24'h00_0000, imm_w} : opb_q;
   alu_pkg::shift_e sh_kind;
   assign sh_kind = form_imm ? alu_pkg::rotate_right_op : kind_w;

   wire [31:0] sh_res;
   wire        sh_c;
   wire        c_old = status_q[alu_pkg::ST_C];

   barrel_shifter u_shift (
      .value     (sh_in),
      .amount    (sh_amt),
      .kind      (sh_kind),
      .rotate_through_carry       (rrx_w),
      .carry_in  (c_old),
      .result    (sh_res),
      .carry_out (sh_c)
   );

   // Index operands refuse register counts and immediates
   wire reject = idx_w & (form_reg | form_imm);

   // ********************
   // ALU
   // ********************
   logic [31:0] ax;
   logic [31:0] ay;
   logic        acin;
   logic        arith;
   logic [31:0] res;
   logic        to_dest;
   logic        is_test;
   logic [32:0] sum;

   always_comb begin
      ax      = opa_q;
      ay      = sh_res;
      acin    = 1'b0;
      arith   = 1'b1;
      to_dest = 1'b1;
      is_test = 1'b0;
      unique case (op_w)
         alu_pkg::add_op: begin
         end
         alu_pkg::add_carry_op:
            acin = c_old;
         alu_pkg::difference_op: begin
            ay   = ~sh_res;
            acin = 1'b1;
         end
         alu_pkg::difference_borrow_op: begin
            ay   = ~sh_res;
            acin = c_old;
         end
         alu_pkg::reverse_difference_op: begin
            ax   = sh_res;
            ay   = ~opa_q;
            acin = 1'b1;
         end
         alu_pkg::reverse_difference_borrow_op: begin
            ax   = sh_res;
            ay   = ~opa_q;
            acin = c_old;
         end
         alu_pkg::compare_op: begin
            ay      = ~sh_res;
            acin    = 1'b1;
            to_dest = 1'b0;
            is_test = 1'b1;
         end
         alu_pkg::compare_negated_op: begin
            to_dest = 1'b0;
            is_test = 1'b1;
         end
         alu_pkg::equivalence_test_op, alu_pkg::mask_test_op: begin
            arith   = 1'b0;
            to_dest = 1'b0;
            is_test = 1'b1;
         end
         default:
            arith = 1'b0;
      endcase
   end

   assign sum = {1'b0, ax} + {1'b0, ay} + {32'h0000_0000, acin};

   always_comb begin
      unique case (op_w)
         alu_pkg::and_op, alu_pkg::mask_test_op: res = opa_q & sh_res;
         alu_pkg::mask_clear_op:                 res = opa_q & ~sh_res;
         alu_pkg::xor_op,
         alu_pkg::equivalence_test_op:           res = opa_q ^ sh_res;
         alu_pkg::disj_op:                       res = opa_q | sh_res;
         alu_pkg::copy_op:                       res = sh_res;
         alu_pkg::copy_inverted_op:              res = ~sh_res;
         default:                                res = sum[31:0];
      endcase
   end

   // ********************
   // Flags
   // ********************
   wire ovf   = (ax[31] == ay[31]) && (sum[31] != ax[31]);
   wire new_n = res[31];
   wire new_z = res == 32'h0000_0000;
   // Logic and copy forms keep V; the shifter hands back the old C when
   // nothing was shifted
   wire new_c = arith ? sum[32] : sh_c;
   wire new_v = arith ? ovf : status_q[alu_pkg::ST_V];
   wire [3:0] new_flags = {new_n, new_z, new_c, new_v};
   wire flag_wr = fw_w | is_test;
   wire run     = exec & ~reject;

   // ********************
   // Read path
   // ********************
   wire [31:0] rd_word =
      (paddr == alu_pkg::OFF_OPA)    ? opa_q :
      (paddr == alu_pkg::OFF_OPB)    ? opb_q :
      (paddr == alu_pkg::OFF_AMT)    ? amt_q :
      (paddr == alu_pkg::OFF_CTRL)   ? ctrl_q :
      (paddr == alu_pkg::OFF_RESULT) ? result_q :
      (paddr == alu_pkg::OFF_STATUS) ? {28'h000_0000, status_q} :
      (paddr == alu_pkg::OFF_INFO)   ? {29'h0, info_q} :
      alu_pkg::WORD_RST;

   // ********************
   // Registers
   // ********************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= alu_pkg::WORD_RST;
      end else begin
         pready_q  <= setup;
         pslverr_q <= setup & ~is_mapped(paddr);
         prdata_q  <= setup ? rd_word : alu_pkg::WORD_RST;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         opa_q <= alu_pkg::WORD_RST;
         opb_q <= alu_pkg::WORD_RST;
         amt_q <= alu_pkg::WORD_RST;
      end else begin
         if (wr_opa) opa_q <= pwdata;
         if (wr_opb) opb_q <= pwdata;
         if (wr_amt) amt_q <= pwdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q   <= alu_pkg::WORD_RST;
         result_q <= alu_pkg::WORD_RST;
         info_q   <= alu_pkg::INFO_RST;
      end else if (exec) begin
         ctrl_q   <= pwdata;
         info_q   <= {run & flag_wr, reject, run & to_dest};
         if (run && to_dest) result_q <= res;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_q <= alu_pkg::STATUS_RST;
      end else if (run && flag_wr) begin
         status_q <= new_flags;
      end else if (wr_st) begin
         status_q <= pwdata[3:0];
      end
   end

   assign prdata  = prdata_q;
   assign pready  = pready_q;
   assign pslverr = pslverr_q;

   // ********************
   // Checks
   // ********************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence go_logic;
      run && flag_wr && !arith;
   endsequence
   sequence go_no_flags;
      run && !flag_wr;
   endsequence
   sequence go_op(alu_pkg::op_e o);
      run && op_w == o;
   endsequence

   wire [5:0] lsl_pos = 6'h20 - {1'b0, sh_amt[4:0]};

   apb_answer_a: assert property (setup |=> pready ##1 !pready)
      else $error("pready not a single cycle after setup");
   flag_hold_a: assert property (go_no_flags |=> $stable(status_q))
      else $error("flags changed without flag write");
   cmp_carry_a: assert property (go_op(alu_pkg::compare_op) |=>
      status_q[alu_pkg::ST_C] == ($past(opa_q) >= $past(sh_res)) && $stable(result_q))
      else $error("compare carry or result wrong");
   copy_inv_a: assert property (go_op(alu_pkg::copy_inverted_op) |=>
      result_q == ~$past(sh_res))
      else $error("inverted copy result wrong");
   adc_sum_a: assert property (go_op(alu_pkg::add_carry_op) |=>
      result_q == $past(opa_q) + $past(sh_res) + {31'h0, $past(c_old)})
      else $error("add with carry result wrong");
   sbc_diff_a: assert property (go_op(alu_pkg::difference_borrow_op) |=>
      result_q == $past(opa_q) - $past(sh_res) - {31'h0, !$past(c_old)})
      else $error("subtract with carry result wrong");
   idx_reject_a: assert property (exec && reject |=>
      info_q[alu_pkg::INFO_REJ] && $stable(result_q) && $stable(status_q))
      else $error("index operand form not refused");
   lsl_carry_a: assert property (!rrx_w && sh_kind == alu_pkg::shift_left_logical &&
      sh_amt != 8'h00 && sh_amt <= alu_pkg::FULL_SHIFT |-> sh_c == sh_in[lsl_pos[4:0]] ||
      (sh_amt == alu_pkg::FULL_SHIFT && sh_c == sh_in[0]))
      else $error("left shift carry wrong");
   asr_fill_a: assert property (sh_kind == alu_pkg::shift_right_signed && !rrx_w &&
      sh_amt >= alu_pkg::FULL_SHIFT |-> sh_res == {32{sh_in[31]}} && sh_c == sh_in[31])
      else $error("signed shift fill wrong");
   imm_rot_a: assert property (form_imm |->
      sh_res == 32'(({24'h00_0000, imm_w, 24'h00_0000, imm_w} >> sh_amt[4:0])))
      else $error("immediate rotation wrong");
   copy_v_a: assert property (go_op(alu_pkg::copy_op) ##0 flag_wr |=>
      $stable(status_q[alu_pkg::ST_V]) && status_q[alu_pkg::ST_C] == $past(sh_c))
      else $error("copy flags wrong");
   logic_v_a: assert property (go_logic |=>
      $stable(status_q[alu_pkg::ST_V]) && status_q[alu_pkg::ST_C] == $past(sh_c))
      else $error("logic op flags wrong");
   sub_diff_a: assert property (go_op(alu_pkg::difference_op) |=>
      result_q == $past(opa_q) - $past(sh_res))
      else $error("subtract result wrong");
endmodule : alu_datapath
`default_nettype wire

// file: verif/apb_master_model.sv
// Purpose: Far-side requester driving the APB slave, one transfer per request
// Assumes: Slave answers with pready at some later edge
// Notes:   Released address and data lines are inverted, never left at last value
`timescale 1ns/10ps
`default_nettype none
module apb_master_model (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        req,
   input  wire logic        wr,
   input  wire logic [7:0]  addr,
   input  wire logic [31:0] wdata,
   output logic             done,
   output logic      [31:0] rdata,
   output logic             err,
   output logic             psel,
   output logic             penable,
   output logic      [7:0]  paddr,
   output logic             pwrite,
   output logic      [31:0] pwdata,
   input  wire logic        pready,
   input  wire logic [31:0] prdata,
   input  wire logic        pslverr
);
   logic [1:0] st_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= 2'h0;
         psel <= 1'b0;
         penable <= 1'b0;
         paddr <= 8'h00;
         pwrite <= 1'b0;
         pwdata <= 32'h0;
         done <= 1'b0;
         rdata <= 32'h0;
         err <= 1'b0;
      end else begin
         done <= 1'b0;
         case (st_q)
            2'h0: if (req) begin
               psel <= 1'b1;
               paddr <= addr;
               pwrite <= wr;
               pwdata <= wdata;
               st_q <= 2'h1;
            end
            2'h1: begin
               penable <= 1'b1;
               st_q <= 2'h2;
            end
            // Request held until pready is seen
            default: if (pready) begin
               rdata <= prdata;
               err <= pslverr;
               done <= 1'b1;
               psel <= 1'b0;
               penable <= 1'b0;
               paddr <= ~paddr;
               pwdata <= ~pwdata;
               st_q <= 2'h0;
            end
         endcase
      end
   end
endmodule : apb_master_model
`default_nettype wire

// file: verif/tb.sv
// Purpose: Directed test of the shift/ALU datapath over APB
// Assumes: Hand-worked expected values per operation
// Notes:   Ops leaving no result expect the previous result to stay
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic pclk, presetn, req, wr, done, err, psel, penable, pwrite, pready, pslverr;
   logic [7:0] addr, paddr;
   logic [31:0] wdata, rdata, pwdata, prdata, rd;
   logic e;
   int miscompares, cmp_count;
   alu_datapath u_alu_datapath (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));
   apb_master_model u_apb_master_model (.pclk(pclk), .presetn(presetn), .req(req), .wr(wr),
      .addr(addr), .wdata(wdata), .done(done), .rdata(rdata), .err(err), .psel(psel),
      .penable(penable), .paddr(paddr), .pwrite(pwrite), .pwdata(pwdata),
      .pready(pready), .prdata(prdata), .pslverr(pslverr));
   task automatic end_of_test;
      $display("counts: %0d compares, %0d mismatches", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
      cmp_count++;
      if (g !== x) begin
         miscompares++;
         $display("BAD %0t %s got %h exp %h", $time, m, g, x);
      end
   endtask : chk
   // Bounded wait on the requester; a hang ends the run
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      req <= 1'b1;
      wr <= w;
      addr <= a;
      wdata <= d;
      @(posedge pclk);
      req <= 1'b0;
      for (n = 0; n < 20; n++) begin
         @(posedge pclk);
         #1;
         if (done === 1'b1) break;
      end
      if (n == 20) begin
         miscompares++;
         $display("BAD %0t bus timeout", $time);
         end_of_test();
      end
      rd = rdata;
      e = err;
   endtask : xfer
   function automatic logic [31:0] cw(int op, int sh, int fm, int ca, int im, int rt, int fw);
      return {6'h00, fw[0], rt[3:0], im[7:0], ca[4:0], fm[1:0], sh[1:0], op[3:0]};
   endfunction : cw
   task automatic rv(input logic [31:0] c, a, b, m, input logic [3:0] s,
      input logic [31:0] r, input logic [3:0] f, input logic [2:0] i);
      xfer(1'b1, alu_pkg::OFF_OPA, a);
      xfer(1'b1, alu_pkg::OFF_OPB, b);
      xfer(1'b1, alu_pkg::OFF_AMT, m);
      xfer(1'b1, alu_pkg::OFF_STATUS, {28'h0, s});
      xfer(1'b1, alu_pkg::OFF_CTRL, c);
      xfer(1'b0, alu_pkg::OFF_RESULT, 32'h0);
      chk(rd, r, "result");
      xfer(1'b0, alu_pkg::OFF_STATUS, 32'h0);
      chk(rd, {28'h0, f}, "flags");
      xfer(1'b0, alu_pkg::OFF_INFO, 32'h0);
      chk(rd, {29'h0, i}, "info");
   endtask : rv
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   initial begin
      presetn = 1'b0;
      req = 1'b0;
      wr = 1'b0;
      addr = 8'h00;
      wdata = 32'h0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      xfer(1'b0, alu_pkg::OFF_STATUS, 32'h0);
      chk(rd, 32'h0, "status reset");
      xfer(1'b0, alu_pkg::OFF_INFO, 32'h0);
      chk(rd, 32'h0, "info reset");
      $display("test reset done");
      rv(cw(7,0,1,4,0,0,1), 32'h0, 32'hF0000001, 32'h0, 4'h0, 32'h10, 4'h2, 3'h5);
      rv(cw(7,1,1,0,0,0,1), 32'h0, 32'h80000000, 32'h0, 4'h1, 32'h0, 4'h7, 3'h5);
      rv(cw(7,2,2,0,0,0,1), 32'h0, 32'h80000000, 32'h140, 4'h0, 32'hFFFFFFFF, 4'hA, 3'h5);
      rv(cw(7,0,2,0,0,0,1), 32'h0, 32'h12345678, 32'h100, 4'h2, 32'h12345678, 4'h2, 3'h5);
      rv(cw(7,0,2,0,0,0,1), 32'h0, 32'hFFFFFFFF, 32'h21, 4'h2, 32'h0, 4'h4, 3'h5);
      rv(cw(7,3,2,0,0,0,1), 32'h0, 32'hF1, 32'h8, 4'h0, 32'hF1000000, 4'hA, 3'h5);
      rv(cw(7,3,1,0,0,0,1), 32'h0, 32'h2, 32'h0, 4'h2, 32'h80000001, 4'h8, 3'h5);
      rv(cw(7,0,3,0,4,1,1), 32'h0, 32'h0, 32'h0, 4'h2, 32'h1, 4'h0, 3'h5);
      rv(cw(8,0,3,0,2,1,1), 32'h0, 32'h0, 32'h0, 4'h0, 32'h7FFFFFFF, 4'h2, 3'h5);
      rv(cw(1,0,0,0,0,0,1), 32'hFFFFFFFF, 32'h0, 32'h0, 4'h2, 32'h0, 4'h6, 3'h5);
      rv(cw(0,0,0,0,0,0,1), 32'h7FFFFFFF, 32'h1, 32'h0, 4'h0, 32'h80000000, 4'h9, 3'h5);
      rv(cw(13,0,0,0,0,0,1), 32'h80000000, 32'h1, 32'h0, 4'h0, 32'h7FFFFFFF, 4'h3, 3'h5);
      rv(cw(12,0,0,0,0,0,1), 32'h5, 32'h3, 32'h0, 4'h0, 32'h1, 4'h2, 3'h5);
      rv(cw(10,0,0,0,0,0,1), 32'h3, 32'h5, 32'h0, 4'h0, 32'h2, 4'h2, 3'h5);
      rv(cw(11,0,0,0,0,0,1), 32'h5, 32'h3, 32'h0, 4'h0, 32'hFFFFFFFD, 4'h8, 3'h5);
      rv(cw(3,0,0,0,0,0,1), 32'hFF00FF00, 32'h0F0F0F0F, 32'h0, 4'h3, 32'hF000F000, 4'hB, 3'h5);
      rv(cw(2,0,0,0,0,0,0), 32'hFF00FF00, 32'h0F0F0F0F, 32'h0, 4'h5, 32'h0F000F00, 4'h5, 3'h1);
      rv(cw(9,0,0,0,0,0,1), 32'hFF00FF00, 32'h0F0F0F0F, 32'h0, 4'h0, 32'hFF0FFF0F, 4'h8, 3'h5);
      rv(cw(6,0,0,0,0,0,1), 32'hFF00FF00, 32'h0F0F0F0F, 32'h0, 4'h0, 32'hF00FF00F, 4'h8, 3'h5);
      rv(cw(5,0,0,0,0,0,0), 32'h5, 32'h5, 32'h0, 4'h0, 32'hF00FF00F, 4'h6, 3'h4);
      rv(cw(4,0,0,0,0,0,0), 32'hFFFFFFFF, 32'h1, 32'h0, 4'h0, 32'hF00FF00F, 4'h6, 3'h4);
      rv(cw(14,0,1,1,0,0,0), 32'h80000000, 32'h80000000, 32'h0, 4'h0, 32'hF00FF00F, 4'hA, 3'h4);
      rv(cw(15,0,0,0,0,0,0), 32'hF, 32'hF0, 32'h0, 4'h2, 32'hF00FF00F, 4'h6, 3'h4);
      rv(cw(7,0,2,0,0,0,1) | 32'h04000000, 32'h0, 32'h1, 32'h1, 4'h1, 32'hF00FF00F, 4'h1, 3'h2);
      rv(cw(7,0,1,0,0,0,1) | 32'h04000000, 32'h0, 32'h55, 32'h0, 4'h2, 32'h55, 4'h2, 3'h5);
      $display("test operations done");
      xfer(1'b0, 8'h1C, 32'h0);
      chk({31'h0, e}, 32'h1, "unmapped read error");
      chk(rd, 32'h0, "unmapped read data");
      xfer(1'b1, 8'h1C, 32'hDEADBEEF);
      chk({31'h0, e}, 32'h1, "unmapped write error");
      // Read-only result must ignore writes
      xfer(1'b1, alu_pkg::OFF_RESULT, 32'hDEADBEEF);
      xfer(1'b0, alu_pkg::OFF_RESULT, 32'h0);
      chk(rd, 32'h55, "result read only");
      $display("test bus done");
      end_of_test();
   end
endmodule : tb
`default_nettype wire
